// ---- src/generator_fault_supervisor.sv ----
// engine fault supervisor with flash code output and wishbone registers
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
// Summary of operation
// - oil pressure trip armed after bypass; stops engine, code 1-1
// - high oil temperature stops engine, latches code 1-2
// - overspeed stops engine, latches code 1-3
// - underspeed armed after bypass; stops engine, code 1-4
// - too many failed cranks stops cranking, latches code 1-4
// - speed signal lost past delay shuts down, code 1-5
// - overvoltage past delay shuts down, code 2-1
// - starting system fault gives code 2-2 without shutdown
// - output below half nominal stops engine, code 2-4
// - steady light when enabled and fault free, dark when off; 2-3 unused
// - the highest priority latched alarm drives its flash code; each alarm shows in alarm register
// - alarms stay latched until explicitly cleared
// - run inhibit holds the unit disabled
// - voltage target is the normal/extended setting
// - current limit output is the configured setting
// - low battery request ends on low current and removal condition
// - other requests keep unit running at normal voltage
// - crank up to crank time, rest before retry
// - count crank attempts, stop at configured count
// - inhibit blocks start, clears requests, stops engine
module generator_fault_supervisor
	import gen_sup_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire sense_t sense_i,
	input wire logic inhibit_i,
	input wire logic lowbat_req_i,
	input wire logic lowbat_remove_i,
	input wire logic other_req_i,
	output drive_t drive_o
);
	// pin inputs through two flops
	sense_t s1_r, s2_r;
	logic [3:0] p1_r, p2_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= '0;
			s2_r <= '0;
			p1_r <= 4'h0;
			p2_r <= 4'h0;
		end else begin
			s1_r <= sense_i;
			s2_r <= s1_r;
			p1_r <= {inhibit_i, lowbat_req_i, lowbat_remove_i, other_req_i};
			p2_r <= p1_r;
		end
	end
	logic inh, lb_req, lb_rem, oth_req;
	assign {inh, lb_req, lb_rem, oth_req} = p2_r;

	// register file
	logic run_en_r, run_en_nxt;
	logic [15:0] ovs_r, ovs_nxt, uns_r, uns_nxt;
	logic [11:0] temp_r, temp_nxt, hvs_r, hvs_nxt, vnom_r, vnom_nxt, vset_r, vset_nxt;
	logic [11:0] ilim_r, ilim_nxt, ifin_r, ifin_nxt;
	logic [3:0] cyc_set_r, cyc_set_nxt;
	logic [7:0] crank_s_r, crank_s_nxt, rest_s_r, rest_s_nxt, byp_s_r, byp_s_nxt;
	logic ack_r, ack_nxt, clr_pulse;
	logic [31:0] rdat_r, rdat_nxt;
	logic [ALM_N-1:0] alarm_r, alarm_nxt, alarm_set;
	eng_t st_r, st_nxt;
	logic req_r, req_nxt;
	logic [3:0] tries_r, tries_nxt;
	wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
	wire rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r;
	assign clr_pulse = wr && wb_adr_i == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_CLR];
	always_comb begin
		run_en_nxt = run_en_r;
		ovs_nxt = ovs_r;
		uns_nxt = uns_r;
		temp_nxt = temp_r;
		hvs_nxt = hvs_r;
		vnom_nxt = vnom_r;
		vset_nxt = vset_r;
		ilim_nxt = ilim_r;
		ifin_nxt = ifin_r;
		cyc_set_nxt = cyc_set_r;
		crank_s_nxt = crank_s_r;
		rest_s_nxt = rest_s_r;
		byp_s_nxt = byp_s_r;
		ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
		rdat_nxt = rdat_r;
		if (wr && wb_sel_i[0] && wb_adr_i == OFS_CTRL) begin
			run_en_nxt = wb_dat_i[CTRL_RUN];
		end
		if (wr && wb_sel_i[1:0] == 2'b11) begin
			case (wb_adr_i)
				OFS_OVS: ovs_nxt = wb_dat_i[15:0];
				OFS_UNS: uns_nxt = wb_dat_i[15:0];
				OFS_TEMP: temp_nxt = wb_dat_i[11:0];
				OFS_HVS: hvs_nxt = wb_dat_i[11:0];
				OFS_VNOM: vnom_nxt = wb_dat_i[11:0];
				OFS_VSET: vset_nxt = wb_dat_i[11:0];
				OFS_ILIM: ilim_nxt = wb_dat_i[11:0];
				OFS_IFIN: ifin_nxt = wb_dat_i[11:0];
				default: ;
			endcase
		end
		if (wr && wb_adr_i == OFS_CRANK && wb_sel_i == 4'hf) begin
			cyc_set_nxt = wb_dat_i[27:24];
			byp_s_nxt = wb_dat_i[23:16];
			rest_s_nxt = wb_dat_i[15:8];
			crank_s_nxt = wb_dat_i[7:0];
		end
		if (rd) begin
			case (wb_adr_i)
				OFS_CTRL: rdat_nxt = {31'h0, run_en_r};
				OFS_OVS: rdat_nxt = {16'h0000, ovs_r};
				OFS_UNS: rdat_nxt = {16'h0000, uns_r};
				OFS_TEMP: rdat_nxt = {20'h0_0000, temp_r};
				OFS_HVS: rdat_nxt = {20'h0_0000, hvs_r};
				OFS_VNOM: rdat_nxt = {20'h0_0000, vnom_r};
				OFS_VSET: rdat_nxt = {20'h0_0000, vset_r};
				OFS_ILIM: rdat_nxt = {20'h0_0000, ilim_r};
				OFS_IFIN: rdat_nxt = {20'h0_0000, ifin_r};
				OFS_CRANK: rdat_nxt = {4'h0, cyc_set_r, byp_s_r, rest_s_r, crank_s_r};
				OFS_STAT: rdat_nxt = {23'h0, req_r, tries_r, 1'b0, st_r};
				OFS_ALARM: rdat_nxt = {23'h0, alarm_r};
				default: rdat_nxt = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			run_en_r <= 1'b0;
			ovs_r <= OVS_RST;
			uns_r <= UNS_RST;
			temp_r <= TEMP_RST;
			hvs_r <= HVS_RST;
			vnom_r <= VNOM_RST;
			vset_r <= VSET_RST;
			ilim_r <= ILIM_RST;
			ifin_r <= IFIN_RST;
			cyc_set_r <= CRANK_CYC_RST;
			crank_s_r <= CRANK_S_RST;
			rest_s_r <= REST_S_RST;
			byp_s_r <= BYPASS_S_RST;
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			run_en_r <= run_en_nxt;
			ovs_r <= ovs_nxt;
			uns_r <= uns_nxt;
			temp_r <= temp_nxt;
			hvs_r <= hvs_nxt;
			vnom_r <= vnom_nxt;
			vset_r <= vset_nxt;
			ilim_r <= ilim_nxt;
			ifin_r <= ifin_nxt;
			cyc_set_r <= cyc_set_nxt;
			crank_s_r <= crank_s_nxt;
			rest_s_r <= rest_s_nxt;
			byp_s_r <= byp_s_nxt;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// 100 ms tick
	logic [31:0] pre_r, pre_nxt;
	logic tick;
	assign tick = pre_r == 32'(TICK_CYCLES - 1);
	always_comb pre_nxt = tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;

	// qualification timers and speed failure
	logic [7:0] nsp_r, nsp_nxt, ovv_r, ovv_nxt, tmr_r, tmr_nxt;
	wire running = st_r == ST_BYPASS || st_r == ST_RUN;
	wire armed = st_r == ST_RUN;
	wire ovv_cond = s2_r.volt > hvs_r;
	always_comb begin
		nsp_nxt = (running && !s2_r.spd_ok) ? nsp_r + 8'(tick) : 8'h00;
		ovv_nxt = (running && ovv_cond) ? ovv_r + 8'(tick) : 8'h00;
	end
	// hardware set wins over a clear in the same cycle
	always_comb begin
		alarm_set = '0;
		alarm_set[ALM_OIL] = armed && s2_r.oil_low;
		alarm_set[ALM_TEMP] = running && s2_r.temp > temp_r;
		alarm_set[ALM_OVS] = running && s2_r.rpm > ovs_r;
		alarm_set[ALM_UNS] = armed && s2_r.rpm < uns_r;
		alarm_set[ALM_OCR] = st_r == ST_REST && tries_r >= cyc_set_r;
		alarm_set[ALM_NOSPD] = nsp_r >= 8'(NOSPD_TICKS);
		alarm_set[ALM_OVV] = ovv_r >= 8'(OVV_TICKS);
		alarm_set[ALM_STS] = s2_r.start_fault;
		alarm_set[ALM_LVS] = armed && s2_r.volt < {1'b0, vnom_r[11:1]};
		alarm_nxt = (clr_pulse ? '0 : alarm_r) | alarm_set;
	end
	wire [ALM_N-1:0] shut_mask = ~(ALM_N'(1) << ALM_STS);
	wire trip = |(alarm_r & shut_mask);

	// run request bookkeeping
	always_comb begin
		req_nxt = req_r;
		if (lb_req) begin
			req_nxt = 1'b1;
		end else if (req_r && s2_r.amps < ifin_r && lb_rem) begin
			req_nxt = 1'b0;
		end
		if (inh || !run_en_r) begin
			req_nxt = 1'b0;
		end
	end
	wire call = (req_r || oth_req) && run_en_r && !inh;

	// engine sequencer
	always_comb begin
		st_nxt = st_r;
		tries_nxt = tries_r;
		tmr_nxt = tmr_r + 8'(tick);
		case (st_r)
			ST_IDLE: begin
				tmr_nxt = 8'h00;
				tries_nxt = 4'h0;
				if (call && !trip) begin
					st_nxt = ST_CRANK;
					tries_nxt = 4'h1;
				end
			end
			ST_CRANK: begin
				if (s2_r.spd_ok && s2_r.rpm >= uns_r) begin
					st_nxt = ST_BYPASS;
					tmr_nxt = 8'h00;
				end else if (tmr_r >= crank_s_r) begin
					st_nxt = ST_REST;
					tmr_nxt = 8'h00;
				end
			end
			ST_REST: begin
				if (tries_r >= cyc_set_r) begin
					st_nxt = ST_FAULT;
				end else if (tmr_r >= rest_s_r) begin
					st_nxt = ST_CRANK;
					tries_nxt = tries_r + 4'h1;
					tmr_nxt = 8'h00;
				end
			end
			ST_BYPASS: begin
				if (tmr_r >= byp_s_r) begin
					st_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!call) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_FAULT: begin
				if (!trip) begin
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
		if (trip && st_r != ST_IDLE) begin
			st_nxt = ST_FAULT;
		end
		if (inh && st_r != ST_FAULT) begin
			st_nxt = ST_IDLE;
		end
	end

	// flash code: first digit, gap, second digit, gap; each gap is GAP_TICKS + 1 ticks long
	logic [3:0] code;
	always_comb begin
		code = 4'h0;
		if (alarm_r[ALM_LVS]) code = 4'h4;
		else if (alarm_r[ALM_OVV]) code = 4'h1;
		else if (alarm_r[ALM_NOSPD]) code = 4'hd;
		else if (alarm_r[ALM_OCR] || alarm_r[ALM_UNS]) code = 4'hc;
		else if (alarm_r[ALM_OVS]) code = 4'hb;
		else if (alarm_r[ALM_TEMP]) code = 4'ha;
		else if (alarm_r[ALM_OIL]) code = 4'h9;
		else if (alarm_r[ALM_STS]) code = 4'h2;
	end
	// code packs: bit3 set means first digit 1 else 2; low bits second digit
	wire [2:0] dig1 = code[3] ? 3'd1 : 3'd2;
	wire [2:0] dig2 = code[2:0];
	logic [5:0] ph_r, ph_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic dig_r, dig_nxt, led;
	always_comb begin
		ph_nxt = ph_r + 6'(tick);
		cnt_nxt = cnt_r;
		dig_nxt = dig_r;
		if (tick && ph_r == 6'(2 * BLINK_TICKS - 1) && cnt_r != 3'd0) begin
			ph_nxt = 6'd0;
			cnt_nxt = cnt_r - 3'd1;
		end else if (tick && ph_r >= 6'(GAP_TICKS)) begin
			ph_nxt = 6'd0;
			dig_nxt = !dig_r;
			cnt_nxt = dig_r ? dig1 : dig2;
		end
		if (code == 4'h0) begin
			ph_nxt = 6'd0;
			cnt_nxt = 3'd0;
			dig_nxt = 1'b1;
		end
		if (code == 4'h0) led = run_en_r && !inh;
		else led = cnt_r != 3'd0 && ph_r < 6'(BLINK_TICKS);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pre_r <= 32'h0000_0000;
			nsp_r <= 8'h00;
			ovv_r <= 8'h00;
			tmr_r <= 8'h00;
			alarm_r <= '0;
			req_r <= 1'b0;
			st_r <= ST_IDLE;
			tries_r <= 4'h0;
			ph_r <= 6'd0;
			cnt_r <= 3'd0;
			dig_r <= 1'b1;
			drive_o <= '0;
		end else begin
			pre_r <= pre_nxt;
			nsp_r <= nsp_nxt;
			ovv_r <= ovv_nxt;
			tmr_r <= tmr_nxt;
			alarm_r <= alarm_nxt;
			req_r <= req_nxt;
			st_r <= st_nxt;
			tries_r <= tries_nxt;
			ph_r <= ph_nxt;
			cnt_r <= cnt_nxt;
			dig_r <= dig_nxt;
			drive_o.crank <= st_nxt == ST_CRANK;
			drive_o.fuel <= st_nxt == ST_CRANK || st_nxt == ST_BYPASS || st_nxt == ST_RUN;
			drive_o.v_target <= vset_r;
			drive_o.i_limit <= ilim_r;
			drive_o.led <= led;
		end
	end

	a_oil_trip: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(armed && s2_r.oil_low) |=> alarm_r[ALM_OIL] ##1 !drive_o.fuel) else $error("oil trip missed");
	a_temp_trip: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(running && s2_r.temp > temp_r) |=> alarm_r[ALM_TEMP]) else $error("temp trip missed");
	a_ovs_trip: assert property (@(posedge clk_sys) disable iff (!rst_n)
		alarm_r[ALM_OVS] |-> ##[0:2] !drive_o.fuel) else $error("overspeed no stop");
	a_uns_bypass: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(alarm_r[ALM_UNS]) |-> $past(st_r) == ST_RUN) else $error("underspeed before bypass");
	a_latch_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(alarm_r[ALM_OVS] && !clr_pulse) |=> alarm_r[ALM_OVS]) else $error("alarm dropped");
	a_inhibit_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		inh |-> ##[1:2] !drive_o.crank && !drive_o.fuel) else $error("inhibit ignored");
	a_crank_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_r == ST_CRANK |-> tries_r <= cyc_set_r) else $error("too many cranks");
	a_start_no_stop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(st_r == ST_RUN && alarm_r == (ALM_N'(1) << ALM_STS) && call) |=> st_r == ST_RUN)
		else $error("starting fault stopped engine");
	a_lowbat_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$fell(req_r) |-> $past(s2_r.amps < ifin_r && lb_rem) || $past(inh || !run_en_r))
		else $error("low battery request ended early");
	c_run: cover property (@(posedge clk_sys) disable iff (!rst_n) st_r == ST_BYPASS ##1 st_r == ST_RUN);
	c_ocr: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(alarm_r[ALM_OCR]));
	c_clear: cover property (@(posedge clk_sys) disable iff (!rst_n) clr_pulse && alarm_r != '0);
endmodule : generator_fault_supervisor

// ---- common/gen_sup_pkg.sv ----
// constants, register map and types for the generator fault supervisor
package gen_sup_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_OVS = 6'h04;
	localparam logic [5:0] OFS_UNS = 6'h08;
	localparam logic [5:0] OFS_TEMP = 6'h0c;
	localparam logic [5:0] OFS_HVS = 6'h10;
	localparam logic [5:0] OFS_VNOM = 6'h14;
	localparam logic [5:0] OFS_VSET = 6'h18;
	localparam logic [5:0] OFS_ILIM = 6'h1c;
	localparam logic [5:0] OFS_IFIN = 6'h20;
	localparam logic [5:0] OFS_CRANK = 6'h24;
	localparam logic [5:0] OFS_STAT = 6'h28;
	localparam logic [5:0] OFS_ALARM = 6'h2c;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_CLR = 1;
	localparam logic [15:0] OVS_RST = 16'h0e10;
	localparam logic [15:0] UNS_RST = 16'h0bb8;
	localparam logic [11:0] TEMP_RST = 12'h0078;
	localparam logic [11:0] HVS_RST = 12'h0258;
	localparam logic [11:0] VNOM_RST = 12'h01e0;
	localparam logic [11:0] VSET_RST = 12'h0244;
	localparam logic [11:0] ILIM_RST = 12'h01c2;
	localparam logic [11:0] IFIN_RST = 12'h0032;
	localparam logic [3:0] CRANK_CYC_RST = 4'h3;
	localparam logic [7:0] CRANK_S_RST = 8'h05;
	localparam logic [7:0] REST_S_RST = 8'h0a;
	localparam logic [7:0] BYPASS_S_RST = 8'h0a;
	localparam int MS_NS = 1_000_000;
	localparam int CLK_NS = 40;
	localparam int TICK_MS = 100;
	localparam int TICK_CYC = TICK_MS * (MS_NS / CLK_NS);
	localparam int BLINK_TICKS = 4;
	localparam int GAP_TICKS = 12;
	localparam int NOSPD_MS = 2000;
	localparam int OVV_MS = 1000;
	localparam int NOSPD_TICKS = NOSPD_MS / TICK_MS;
	localparam int OVV_TICKS = OVV_MS / TICK_MS;
	localparam int ALM_N = 9;
	localparam int ALM_OIL = 0;
	localparam int ALM_TEMP = 1;
	localparam int ALM_OVS = 2;
	localparam int ALM_UNS = 3;
	localparam int ALM_OCR = 4;
	localparam int ALM_NOSPD = 5;
	localparam int ALM_OVV = 6;
	localparam int ALM_STS = 7;
	localparam int ALM_LVS = 8;
	typedef struct packed {
		logic [15:0] rpm;
		logic [11:0] temp;
		logic [11:0] volt;
		logic [11:0] amps;
		logic oil_low;
		logic spd_ok;
		logic start_fault;
	} sense_t;
	typedef struct packed {
		logic crank;
		logic fuel;
		logic [11:0] v_target;
		logic [11:0] i_limit;
		logic led;
	} drive_t;
	typedef enum logic [2:0] {ST_IDLE, ST_CRANK, ST_REST, ST_BYPASS, ST_RUN, ST_FAULT} eng_t;
endpackage : gen_sup_pkg

// ---- tb/engine_model.sv ----
// behavioural engine, alternator and sensor model for the supervisor bench
`timescale 1ns/10ps
module engine_model
	import gen_sup_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire drive_t drive_i,
	input wire logic [3:0] inj_i,
	input wire logic no_start_i,
	input wire logic [11:0] amps_i,
	output sense_t sense_o
);
	logic run_r;
	logic run_nxt;
	// catches on the starter alone, dies the moment fuel hold is cut
	always_comb begin
		run_nxt = (drive_i.crank & !no_start_i) | (run_r & drive_i.fuel);
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= 1'b0;
		end else begin
			run_r <= run_nxt;
		end
	end
	// oil switch is closed whenever the engine stands, no kinder than the real one
	always_comb begin
		sense_o.rpm = !run_r ? 16'h0000 : (inj_i == 4'h3) ? 16'h0fa0 : (inj_i == 4'h4) ? 16'h07d0 : 16'h0ce4;
		sense_o.temp = (inj_i == 4'h2) ? 12'h00c8 : 12'h0050;
		sense_o.volt = !run_r ? 12'h000 : (inj_i == 4'h6) ? 12'h02bc : (inj_i == 4'h8) ? 12'h064 : 12'h244;
		sense_o.amps = amps_i;
		sense_o.oil_low = !run_r | (inj_i == 4'h1);
		sense_o.spd_ok = (inj_i != 4'h5);
		sense_o.start_fault = (inj_i == 4'h7);
	end
endmodule : engine_model

// ---- tb/testbench.sv ----
// self-checking bench for the generator fault supervisor
`timescale 1ns/10ps
module testbench;
	import gen_sup_pkg::*;
	localparam int TK = 4;
	logic clk_sys, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic [ADDR_W-1:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0] wb_sel_i, inj;
	logic inhibit_i, lowbat_req_i, lowbat_remove_i, other_req_i, no_start;
	logic [11:0] amps;
	sense_t sense_i;
	drive_t drive_o;
	int bad_count, num_checks, n;
	int alm_bit [8] = '{0, 1, 2, 3, 5, 6, 7, 8};
	generator_fault_supervisor #(.TICK_CYCLES(TK)) u_generator_fault_supervisor (.clk_sys(clk_sys), .rst_n(rst_n),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sense_i(sense_i), .inhibit_i(inhibit_i),
		.lowbat_req_i(lowbat_req_i), .lowbat_remove_i(lowbat_remove_i), .other_req_i(other_req_i), .drive_o(drive_o));
	engine_model u_engine_model (.clk_sys(clk_sys), .rst_n(rst_n), .drive_i(drive_o), .inj_i(inj),
		.no_start_i(no_start), .amps_i(amps), .sense_o(sense_i));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// entered just after a rising edge; ack seen settled, then taken at the next rising edge
	task automatic wb_cycle(input logic [ADDR_W-1:0] adr, input logic we, input logic [31:0] dat,
		output logic [31:0] q);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hf;
		k = 0;
		do begin
			@(negedge clk_sys);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		@(posedge clk_sys);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_sys);
		if (k >= 50) begin
			bad_count++;
			stop_test();
		end
	endtask : wb_cycle
	// polls a register until the masked field matches, bounded
	task automatic wait_reg(input logic [ADDR_W-1:0] adr, input logic [31:0] mask, input logic [31:0] val);
		int k;
		k = 0;
		do begin
			wb_cycle(adr, 1'b0, 32'h0000_0000, rd);
			k++;
		end while ((rd & mask) !== val && k < 400);
		if ((rd & mask) !== val) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, rd & mask, val);
			stop_test();
		end
	endtask : wait_reg
	initial begin
		rst_n = 1'b0;
		{wb_we_i, wb_cyc_i, wb_stb_i, inhibit_i, lowbat_req_i, lowbat_remove_i, other_req_i, no_start} = '0;
		wb_adr_i = '0;
		wb_dat_i = '0;
		wb_sel_i = '0;
		inj = 4'h0;
		amps = 12'h064;
		bad_count = 0;
		num_checks = 0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check({31'h0, drive_o.led}, 32'h0000_0000);
		wb_cycle(OFS_OVS, 1'b0, 32'h0000_0000, rd);
		check(rd, {16'h0000, OVS_RST});
		wb_cycle(6'h30, 1'b1, 32'hffff_ffff, rd);
		wb_cycle(6'h30, 1'b0, 32'h0000_0000, rd);
		check(rd, 32'h0000_0000);
		wb_cycle(OFS_ILIM, 1'b1, 32'h0000_0100, rd);
		check({20'h0, drive_o.i_limit}, 32'h0000_0100);
		// short crank 2, rest 2, bypass 3 ticks, two attempts
		wb_cycle(OFS_CRANK, 1'b1, 32'h0203_0202, rd);
		wb_cycle(OFS_CTRL, 1'b1, 32'h0000_0001, rd);
		repeat (4) @(posedge clk_sys);
		check({31'h0, drive_o.led}, 32'h0000_0001);
		no_start <= 1'b1;
		other_req_i <= 1'b1;
		n = 0;
		while (drive_o.crank !== 1'b1 && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		n = 0;
		while (drive_o.crank === 1'b1 && n < 200) begin
			@(posedge clk_sys);
			n++;
		end
		check(32'(n >= 5 && n <= 2 * TK + 1), 32'h0000_0001);
		wait_reg(OFS_ALARM, 32'h0000_0010, 32'h0000_0010);
		check({31'h0, drive_o.crank}, 32'h0000_0000);
		wb_cycle(OFS_STAT, 1'b0, 32'h0000_0000, rd);
		check({28'h0, rd[7:4]}, 32'h0000_0002);
		no_start <= 1'b0;
		wb_cycle(OFS_CTRL, 1'b1, 32'h0000_0003, rd);
		for (int i = 0; i < 8; i++) begin
			wait_reg(OFS_STAT, 32'h0000_0007, 32'h0000_0004);
			if (i == 0) begin
				check({20'h0, drive_o.v_target}, {20'h0, VSET_RST});
			end
			inj <= 4'(i + 1);
			if (i == 5) begin
				repeat (20) @(posedge clk_sys);
				wb_cycle(OFS_ALARM, 1'b0, 32'h0000_0000, rd);
				check(rd, 32'h0000_0000);
			end
			wait_reg(OFS_ALARM, 32'h0000_0001 << alm_bit[i], 32'h0000_0001 << alm_bit[i]);
			check({31'h0, drive_o.fuel}, {31'h0, i == 6});
			if (i == 1) begin
				n = 0;
				while (drive_o.led === 1'b1 && n < 500) begin
					@(posedge clk_sys);
					n++;
				end
				while (drive_o.led !== 1'b1 && n < 500) begin
					@(posedge clk_sys);
					n++;
				end
				n = 0;
				while (drive_o.led === 1'b1 && n < 500) begin
					@(posedge clk_sys);
					n++;
				end
				check(32'(n), 32'(BLINK_TICKS * TK));
			end
			inj <= 4'h0;
			repeat (4) @(posedge clk_sys);
			wb_cycle(OFS_ALARM, 1'b0, 32'h0000_0000, rd);
			check(rd, 32'h0000_0001 << alm_bit[i]);
			wb_cycle(OFS_CTRL, 1'b1, 32'h0000_0003, rd);
			wb_cycle(OFS_ALARM, 1'b0, 32'h0000_0000, rd);
			check(rd, 32'h0000_0000);
		end
		wait_reg(OFS_STAT, 32'h0000_0007, 32'h0000_0004);
		inhibit_i <= 1'b1;
		repeat (10) @(posedge clk_sys);
		check({29'h0, drive_o.fuel, drive_o.crank, drive_o.led}, 32'h0000_0000);
		inhibit_i <= 1'b0;
		other_req_i <= 1'b0;
		lowbat_req_i <= 1'b1;
		repeat (4) @(posedge clk_sys);
		lowbat_req_i <= 1'b0;
		repeat (4) @(posedge clk_sys);
		wb_cycle(OFS_STAT, 1'b0, 32'h0000_0000, rd);
		check({31'h0, rd[8]}, 32'h0000_0001);
		lowbat_remove_i <= 1'b1;
		repeat (4) @(posedge clk_sys);
		wb_cycle(OFS_STAT, 1'b0, 32'h0000_0000, rd);
		check({31'h0, rd[8]}, 32'h0000_0001);
		amps <= 12'h010;
		repeat (4) @(posedge clk_sys);
		wb_cycle(OFS_STAT, 1'b0, 32'h0000_0000, rd);
		check({31'h0, rd[8]}, 32'h0000_0000);
		stop_test();
	end
endmodule : testbench
